//--- include/uif_defs.svh
// Purpose: Offsets, bit positions, reset values and counts of the UART interrupt block
// Assumes: Plain 8-bit register port on 16-bit addresses, one system clock
// Notes:   Overview follows
//
// Overview of operation
// [RL1] Master enable gates every interrupt request; it resets to zero.
// [RL2] Transmit-space flag, bit 6, follows transmit FIFO below threshold; one enables it.
// [RL3] Receive-available flag, bit 5, sets when fill level exceeds threshold; one enables.
// [RL4] Receive-available also sets after idle over threshold times 16 bits, data left.
// [RL5] Receive-available clears on write zero while fill below threshold; disables interrupt.
// [RL6] Receive overflow, bit 4: set on overflow, cleared by write zero or FIFO reset.
// [RL7] Receive underflow, bit 3: set on underflow, cleared by write zero or FIFO reset.
// [RL8] Transmit overflow, bit 2: set on overflow, cleared by write zero or FIFO reset.
// [RL9] Framing error, bit 1: set on bad stop bit, cleared only by write zero.
// [RL10] Transmit done, bit 0: set when FIFO fully sent, cleared only by write zero.
// [RL11] Divisor high byte holds bits 15 to 8, read and write, resets zero.
// [RL12] Clearing block enable resets FIFOs and clears both overflow and underflow flags.
// [RL13] Receive threshold is write-only 4 bits; fill level is read-only, compared against it.
// [RL14] Bit rate is clock over the 16-bit divisor; software never programs zero.
// [RL15] Request is high while master enable and some flag with its enable are set.
`ifndef UIF_DEFS_SVH
`define UIF_DEFS_SVH

`define UIF_ADDR_IRQ       16'h009a
`define UIF_ADDR_BAUD_HI   16'ha0a3
`define UIF_ADDR_CTRL      16'ha0b0
`define UIF_ADDR_EVT       16'ha0b1
`define UIF_ADDR_EVT_MASK  16'ha0b2
`define UIF_ADDR_FILL      16'ha0b3

`define UIF_BIT_MASTER     7
`define UIF_BIT_TXSP       6
`define UIF_BIT_RXAV       5
`define UIF_BIT_RXOV       4
`define UIF_BIT_RXUN       3
`define UIF_BIT_TXOV       2
`define UIF_BIT_FRAMING_ERROR_FLAG       1
`define UIF_BIT_TXDN       0
`define UIF_BIT_IDLE       7
`define UIF_BIT_CTRL_EN    7
`define UIF_THR_MSB        3

`define UIF_RST_BYTE       8'h00
`define UIF_RST_NIB        4'h0
`define UIF_IDLE_SHIFT     4'h0
`define UIF_DIV_ONE        16'h0001

`endif

//--- include/uif_pkg.sv
// Purpose: Types shared by the UART interrupt block
// Assumes: Included after uif_defs.svh
// Notes:   Event pulses come from logic on clk_sys
package uif_pkg;

  // One register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } uif_req_type;

  // One-cycle event pulses from FIFOs, receiver and transmitter
  typedef struct packed {
    logic rx_byte;
    logic rx_overflow;
    logic rx_underflow;
    logic tx_overflow;
    logic framing_error;
    logic tx_done;
  } uif_evt_type;

endpackage : uif_pkg

//--- verilog/uif_baud_tick.sv
// Purpose: One pulse per bit period from the 16-bit baud divisor
// Assumes: Divisor never zero; zero is treated as one to stay safe
// Notes:   Free running on clk_sys
`timescale 1ns/10ps
`include "uif_defs.svh"
module uif_baud_tick #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Divisor in, tick out
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_r;

  // Tick on the last count of each period [RL14]
  assign tick = (divisor <= DIV_W'(`UIF_DIV_ONE)) ||
                (cnt_r >= divisor - DIV_W'(`UIF_DIV_ONE));

  // Period counter
  always_ff @(posedge clk_sys)
  begin
    if (rst || tick)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + DIV_W'(`UIF_DIV_ONE);
  end
endmodule : uif_baud_tick

//--- verilog/uif_idle_timer.sv
// Purpose: Counts idle bit periods and pulses once when past the limit
// Assumes: Tick from uif_baud_tick, same clock
// Notes:   Saturates, so one pulse per idle stretch
`timescale 1ns/10ps
`include "uif_defs.svh"
module uif_idle_timer #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Control
  input  wire logic             bit_tick,
  input  wire logic             armed,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  timeout
);
  logic [CNT_W-1:0] cnt_r;

  // Fire on the tick that takes the count past the limit [RL4]
  assign timeout = armed && bit_tick && (cnt_r == limit);

  // Idle counter, restarted whenever not armed
  always_ff @(posedge clk_sys)
  begin
    if (rst || !armed)
      cnt_r <= '0;
    else if (bit_tick && (cnt_r != '1))
      cnt_r <= cnt_r + CNT_W'(1);
  end
endmodule : uif_idle_timer

//--- verilog/uif_top.sv
// Purpose: Interrupt flags, enables and baud divisor high byte of the UART
// Assumes: All event inputs are clk_sys logic; register port never waits
// Notes:   Read data appear the cycle after the read strobe only
`timescale 1ns/10ps
`include "uif_defs.svh"
module uif_top (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Register port
  input  wire uif_pkg::uif_req_type bus_req,
  output logic [7:0]               bus_rdata,
  // Events and levels from FIFOs, receiver and transmitter
  input  wire uif_pkg::uif_evt_type evt,
  input  wire logic [3:0]          rx_fill_level,
  input  wire logic                tx_below_threshold,
  input  wire logic                rx_line_idle,
  input  wire logic [7:0]          baud_divisor_low,
  // Outputs to the rest of the UART
  output logic [15:0]              baud_divisor,
  output logic [3:0]               rx_threshold,
  output logic                     uart_block_enable,
  output logic                     fifo_reset,
  output logic                     bit_tick,
  // Interrupt
  output logic                     irq
);
  import uif_pkg::*;

  // Configuration state
  logic       master_irq_enable_r;
  logic [6:0] irq_en_r;
  logic [7:0] baud_divisor_high_r;
  logic       uart_block_enable_r;
  logic [3:0] rx_threshold_r;

  // Status flags
  logic tx_space_flag_r;
  logic rx_avail_flag_r;
  logic rx_overflow_flag_r;
  logic rx_underflow_flag_r;
  logic tx_overflow_flag_r;
  logic framing_error_flag_r;
  logic tx_done_flag_r;

  // Event capture and read path
  logic [7:0] evt_r;
  logic [7:0] evt_mask_r;
  logic [7:0] rdata_r;

  // Decode and helper nets
  logic       wr_irq;
  logic       wr_baud;
  logic       wr_ctrl;
  logic       wr_evt;
  logic       wr_mask;
  logic       rx_above_thr;
  logic       rx_below_thr;
  logic       idle_armed;
  logic       idle_timeout;
  logic       rx_avail_set;
  logic [6:0] flags;
  logic [7:0] evt_set;
  logic [7:0] idle_limit;
  logic [7:0] rd_mux;

  // Address decode of write strobes
  assign wr_irq  = bus_req.wr && (bus_req.addr == `UIF_ADDR_IRQ);
  assign wr_baud = bus_req.wr && (bus_req.addr == `UIF_ADDR_BAUD_HI);
  assign wr_ctrl = bus_req.wr && (bus_req.addr == `UIF_ADDR_CTRL);
  assign wr_evt  = bus_req.wr && (bus_req.addr == `UIF_ADDR_EVT);
  assign wr_mask = bus_req.wr && (bus_req.addr == `UIF_ADDR_EVT_MASK);

  // Fill level against threshold
  assign rx_above_thr = rx_fill_level > rx_threshold_r;  // [RL13]
  assign rx_below_thr = rx_fill_level < rx_threshold_r;  // [RL13]

  // Idle timeout runs only while data sits below threshold
  assign idle_armed = rx_line_idle && rx_below_thr && (rx_fill_level != `UIF_RST_NIB)
                      && uart_block_enable_r && !evt.rx_byte;  // [RL4]
  assign idle_limit = {rx_threshold_r, `UIF_IDLE_SHIFT};  // Threshold times 16 [RL4]

  // Bit period from the full divisor
  assign baud_divisor = {baud_divisor_high_r, baud_divisor_low};  // [RL14]

  uif_baud_tick #(
    .DIV_W   (16)
  ) u_baud (
    .clk_sys (clk_sys),
    .rst     (rst),
    .divisor (baud_divisor),
    .tick    (bit_tick)
  );

  uif_idle_timer #(
    .CNT_W    (8)
  ) u_idle (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .bit_tick (bit_tick),
    .armed    (idle_armed),
    .limit    (idle_limit),
    .timeout  (idle_timeout)
  );

  // Receive-available sets on either cause
  assign rx_avail_set = rx_above_thr || idle_timeout;  // [RL3] [RL4]

  // Master enable and per-flag enables; write one enables, zero disables
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      master_irq_enable_r <= 1'b0;  // [RL1]
      irq_en_r            <= '0;
    end
    else if (wr_irq)
    begin
      master_irq_enable_r <= bus_req.wdata[`UIF_BIT_MASTER];  // [RL1]
      irq_en_r            <= bus_req.wdata[`UIF_BIT_TXSP:`UIF_BIT_TXDN];  // [RL2] [RL5]
    end
  end

  // Transmit-space follows its condition with no software clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tx_space_flag_r <= 1'b0;
    else
      tx_space_flag_r <= tx_below_threshold;  // [RL2]
  end

  // Receive-available; a zero write clears only while below threshold
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rx_avail_flag_r <= 1'b0;
    else if (rx_avail_set)
      rx_avail_flag_r <= 1'b1;  // Set beats a clear in the same cycle [RL3]
    else if (wr_irq && !bus_req.wdata[`UIF_BIT_RXAV] && rx_below_thr)
      rx_avail_flag_r <= 1'b0;  // [RL5]
  end

  // Receive overflow; FIFO reset clears it as well
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rx_overflow_flag_r <= 1'b0;
    else if (evt.rx_overflow)
      rx_overflow_flag_r <= 1'b1;  // [RL6]
    else if (fifo_reset || (wr_irq && !bus_req.wdata[`UIF_BIT_RXOV]))
      rx_overflow_flag_r <= 1'b0;  // [RL6] [RL12]
  end

  // Receive underflow
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rx_underflow_flag_r <= 1'b0;
    else if (evt.rx_underflow)
      rx_underflow_flag_r <= 1'b1;  // [RL7]
    else if (fifo_reset || (wr_irq && !bus_req.wdata[`UIF_BIT_RXUN]))
      rx_underflow_flag_r <= 1'b0;  // [RL7] [RL12]
  end

  // Transmit overflow
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tx_overflow_flag_r <= 1'b0;
    else if (evt.tx_overflow)
      tx_overflow_flag_r <= 1'b1;  // [RL8]
    else if (fifo_reset || (wr_irq && !bus_req.wdata[`UIF_BIT_TXOV]))
      tx_overflow_flag_r <= 1'b0;  // [RL8] [RL12]
  end

  // Framing error survives FIFO reset; software alone clears it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      framing_error_flag_r <= 1'b0;
    else if (evt.framing_error)
      framing_error_flag_r <= 1'b1;  // [RL9]
    else if (wr_irq && !bus_req.wdata[`UIF_BIT_FRAMING_ERROR_FLAG])
      framing_error_flag_r <= 1'b0;  // [RL9]
  end

  // Transmit done; the transmitter pulses it when the last byte leaves an empty FIFO
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tx_done_flag_r <= 1'b0;
    else if (evt.tx_done)
      tx_done_flag_r <= 1'b1;  // [RL10]
    else if (wr_irq && !bus_req.wdata[`UIF_BIT_TXDN])
      tx_done_flag_r <= 1'b0;  // [RL10]
  end

  // Divisor high byte
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      baud_divisor_high_r <= `UIF_RST_BYTE;  // [RL11]
    else if (wr_baud)
      baud_divisor_high_r <= bus_req.wdata;  // [RL11]
  end

  // Control: block enable and receive threshold
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      uart_block_enable_r <= 1'b0;
      rx_threshold_r      <= `UIF_RST_NIB;
    end
    else if (wr_ctrl)
    begin
      uart_block_enable_r <= bus_req.wdata[`UIF_BIT_CTRL_EN];
      rx_threshold_r      <= bus_req.wdata[`UIF_THR_MSB:0];  // [RL13]
    end
  end

  // FIFOs held in reset while the block is disabled
  assign fifo_reset        = !uart_block_enable_r;  // [RL12]
  assign uart_block_enable = uart_block_enable_r;
  assign rx_threshold      = rx_threshold_r;

  // Flags in register layout
  assign flags = {tx_space_flag_r, rx_avail_flag_r, rx_overflow_flag_r,
                  rx_underflow_flag_r, tx_overflow_flag_r, framing_error_flag_r,
                  tx_done_flag_r};

  // Event sources for the sticky log; transmit space logs its rising edge only
  assign evt_set = {idle_timeout,
                    tx_below_threshold && !tx_space_flag_r,
                    rx_avail_set && !rx_avail_flag_r,
                    evt.rx_overflow,
                    evt.rx_underflow,
                    evt.tx_overflow,
                    evt.framing_error,
                    evt.tx_done};

  // Sticky event log, write one to clear; a new event wins over its clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      evt_r <= `UIF_RST_BYTE;
    else if (wr_evt)
      evt_r <= (evt_r & ~bus_req.wdata) | evt_set;
    else
      evt_r <= evt_r | evt_set;
  end

  // Event log mask
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      evt_mask_r <= `UIF_RST_BYTE;
    else if (wr_mask)
      evt_mask_r <= bus_req.wdata;
  end

  // Request: enabled flags or unmasked logged events, all behind the master gate
  assign irq = master_irq_enable_r  // [RL1] [RL15]
               && (|(flags & irq_en_r) || |(evt_r & evt_mask_r));

  // Read mux; master enable and threshold are write-only and read zero
  always_comb
  begin
    rd_mux = `UIF_RST_BYTE;
    unique case (bus_req.addr)
      `UIF_ADDR_IRQ:      rd_mux = {1'b0, flags};
      `UIF_ADDR_BAUD_HI:  rd_mux = baud_divisor_high_r;  // [RL11]
      `UIF_ADDR_CTRL:     rd_mux = {uart_block_enable_r, 7'h00};
      `UIF_ADDR_EVT:      rd_mux = evt_r;
      `UIF_ADDR_EVT_MASK: rd_mux = evt_mask_r;
      `UIF_ADDR_FILL:     rd_mux = {4'h0, rx_fill_level};  // [RL13]
      default:            rd_mux = `UIF_RST_BYTE;
    endcase
  end

  // Read data registered for the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys)
  begin
    if (rst || !bus_req.rd)
      rdata_r <= `UIF_RST_BYTE;
    else
      rdata_r <= rd_mux;
  end

  assign bus_rdata = rdata_r;
endmodule : uif_top

//--- dv/uif_top_assertions.sv
// Purpose: Port-level checks of the UART interrupt block
// Assumes: Synchronous active-high reset, one clock
// Notes:   Bound to uif_top below the module
`timescale 1ns/10ps
`include "uif_defs.svh"
module uif_chk (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst,
  // Register port and events
  input wire uif_pkg::uif_req_type bus_req,
  input wire logic [7:0]           bus_rdata,
  input wire uif_pkg::uif_evt_type evt,
  input wire logic [7:0]           baud_divisor_low,
  // Outputs of the block
  input wire logic [15:0]          baud_divisor,
  input wire logic [3:0]           rx_threshold,
  input wire logic                 uart_block_enable,
  input wire logic                 fifo_reset,
  input wire logic                 bit_tick,
  input wire logic                 irq
);
  import uif_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A flag register read with no write squeezed in before it
  sequence s_rd_flags;
    !bus_req.wr ##1 bus_req.rd && bus_req.addr == `UIF_ADDR_IRQ;
  endsequence
  sequence s_hi_wr;
    bus_req.wr && bus_req.addr == `UIF_ADDR_BAUD_HI;
  endsequence
  rdata_zero_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  master_rd_a: assert property (bus_req.rd && bus_req.addr == `UIF_ADDR_IRQ
    |=> !bus_rdata[7])
    else $error("master enable read back as one");
  framing_error_flag_set_a: assert property (evt.framing_error ##1 s_rd_flags |=> bus_rdata[1])
    else $error("framing flag missing after event");
  txdn_set_a: assert property (evt.tx_done ##1 s_rd_flags |=> bus_rdata[0])
    else $error("transmit done flag missing after event");
  fifo_rst_a: assert property (fifo_reset == !uart_block_enable)
    else $error("fifo reset not tied to block enable");
  baud_low_a: assert property (baud_divisor[7:0] == baud_divisor_low)
    else $error("divisor low byte wrong");
  baud_wr_a: assert property (s_hi_wr |=> baud_divisor[15:8] == $past(bus_req.wdata))
    else $error("divisor high byte not written");
  thr_wr_a: assert property (bus_req.wr && bus_req.addr == `UIF_ADDR_CTRL
    |=> rx_threshold == $past(bus_req.wdata[3:0]))
    else $error("receive threshold not written");
  irq_rst_a: assert property ($fell(rst) |-> !irq)
    else $error("interrupt high after reset");
  // A divisor of two held steady must tick every other cycle
  tick_rate_a: assert property (baud_divisor == 16'h0002 ##1 baud_divisor == 16'h0002
    |-> bit_tick != $past(bit_tick))
    else $error("bit tick not every second cycle");
endmodule : uif_chk

bind uif_top uif_chk u_chk (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .evt(evt), .baud_divisor_low(baud_divisor_low),
  .baud_divisor(baud_divisor), .rx_threshold(rx_threshold),
  .uart_block_enable(uart_block_enable), .fifo_reset(fifo_reset), .bit_tick(bit_tick),
  .irq(irq));

//--- dv/uif_far_model.sv
// Purpose: FIFO, receiver and transmitter side seen by the block
// Assumes: Driven only through its tasks
// Notes:   Events are one-cycle pulses launched after a clock edge
`timescale 1ns/10ps
module uif_far_model (
  input wire logic             clk_sys,
  output uif_pkg::uif_evt_type evt,
  output logic [3:0]           rx_fill_level,
  output logic                 tx_below_threshold,
  output logic                 rx_line_idle,
  output logic [7:0]           baud_divisor_low
);
  // Low divisor byte kept nonzero so the bit rate stays defined
  initial
  begin
    evt                = '0;
    rx_fill_level      = 4'h0;
    tx_below_threshold = 1'b0;
    rx_line_idle       = 1'b0;
    baud_divisor_low   = 8'h02;
  end
  // Bit i of the event struct; bit 0 is tx_done and bit 5 is rx_byte, each pulsed alone for one cycle
  task automatic pulse(input int i);
    @(posedge clk_sys) evt <= uif_pkg::uif_evt_type'(6'h01 << i);
    @(posedge clk_sys) evt <= '0;
  endtask : pulse
  // Levels of fill count, transmit space and line idle
  task automatic lv(input logic [3:0] f, input logic t, input logic idl);
    @(posedge clk_sys)
    begin
      rx_fill_level      <= f;
      tx_below_threshold <= t;
      rx_line_idle       <= idl;
    end
  endtask : lv
endmodule : uif_far_model

//--- dv/tb_uif_top.sv
// Purpose: Self-checking bench of the UART interrupt block
// Assumes: 40 MHz clock, reset held three cycles
// Notes:   Rows pair an event index with the flag byte it should give
`timescale 1ns/10ps
`include "uif_defs.svh"
module tb_uif_top;
  import uif_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  uif_req_type bus_req = '0;
  uif_evt_type evt;
  logic [7:0]  bus_rdata, bdl;
  logic [15:0] baud_divisor;
  logic [3:0]  fill, rx_threshold;
  logic        txb, idl, uart_block_enable, fifo_reset, irq;
  int          n_mismatch = 0;
  int          tests_run = 0;
  logic [11:0] rows [5] = '{12'h001, 12'h102, 12'h204, 12'h308, 12'h410};
  always #12.5 clk_sys = ~clk_sys;
  uif_far_model u_far (.clk_sys(clk_sys), .evt(evt), .rx_fill_level(fill),
    .tx_below_threshold(txb), .rx_line_idle(idl), .baud_divisor_low(bdl));
  uif_top u_dut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .evt(evt), .rx_fill_level(fill), .tx_below_threshold(txb), .rx_line_idle(idl),
    .baud_divisor_low(bdl), .baud_divisor(baud_divisor), .rx_threshold(rx_threshold),
    .uart_block_enable(uart_block_enable), .fifo_reset(fifo_reset), .bit_tick(), .irq(irq));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge clk_sys) bus_req <= '0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys) bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys) bus_req <= '0;
    #1 chk(bus_rdata, e);
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Whole run is a few hundred cycles; this leaves ample margin
  initial
  begin
    #(25 * 3000);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`UIF_ADDR_IRQ, 8'h00);
    rd(`UIF_ADDR_BAUD_HI, 8'h00);
    rd(16'h0000, 8'h00);
    chk(irq, 1'b0);
    chk(fifo_reset, 1'b1);
    $display("test reset done");
    // Block enabled first, or the FIFO reset would wipe overflow flags
    wr(`UIF_ADDR_CTRL, 8'h80);
    foreach (rows[k])
    begin
      u_far.pulse(int'(rows[k][11:8]));
      rd(`UIF_ADDR_IRQ, rows[k][7:0]);
      wr(`UIF_ADDR_IRQ, 8'h00);
      rd(`UIF_ADDR_IRQ, 8'h00);
    end
    $display("test flag rows done");
    u_far.pulse(1);
    wr(`UIF_ADDR_IRQ, 8'h82);
    #1 chk(irq, 1'b1);
    wr(`UIF_ADDR_IRQ, 8'h02);
    #1 chk(irq, 1'b0);
    wr(`UIF_ADDR_IRQ, 8'h80);
    #1 chk(irq, 1'b0);
    rd(`UIF_ADDR_IRQ, 8'h00);
    $display("test interrupt done");
    // Log holds every event so far; a write of ones clears only those bits
    rd(`UIF_ADDR_EVT, 8'h1f);
    wr(`UIF_ADDR_EVT, 8'h1e);
    rd(`UIF_ADDR_EVT, 8'h01);
    wr(`UIF_ADDR_EVT_MASK, 8'h08);
    rd(`UIF_ADDR_EVT_MASK, 8'h08);
    u_far.pulse(3);
    #1 chk(irq, 1'b1);
    wr(`UIF_ADDR_IRQ, 8'h00);
    #1 chk(irq, 1'b0);
    wr(`UIF_ADDR_EVT, 8'h09);
    rd(`UIF_ADDR_EVT, 8'h00);
    rd(`UIF_ADDR_FILL, 8'h00);
    $display("test event log done");
    u_far.lv(4'h0, 1'b1, 1'b0);
    rd(`UIF_ADDR_IRQ, 8'h40);
    u_far.lv(4'h0, 1'b0, 1'b0);
    rd(`UIF_ADDR_IRQ, 8'h00);
    wr(`UIF_ADDR_CTRL, 8'h82);
    u_far.lv(4'h3, 1'b0, 1'b0);
    rd(`UIF_ADDR_IRQ, 8'h20);
    wr(`UIF_ADDR_IRQ, 8'h00);
    rd(`UIF_ADDR_IRQ, 8'h20);
    u_far.lv(4'h1, 1'b0, 1'b0);
    wr(`UIF_ADDR_IRQ, 8'h00);
    rd(`UIF_ADDR_IRQ, 8'h00);
    // Threshold 2 times 16 bit periods of two cycles each
    // A received byte part way restarts the idle count, so no flag yet at 90 cycles
    u_far.lv(4'h1, 1'b0, 1'b1);
    repeat (50) @(posedge clk_sys);
    u_far.pulse(5);
    repeat (40) @(posedge clk_sys);
    rd(`UIF_ADDR_IRQ, 8'h00);
    repeat (40) @(posedge clk_sys);
    rd(`UIF_ADDR_IRQ, 8'h20);
    $display("test receive data done");
    u_far.pulse(3);
    wr(`UIF_ADDR_CTRL, 8'h00);
    rd(`UIF_ADDR_IRQ, 8'h20);
    chk(fifo_reset, 1'b1);
    wr(`UIF_ADDR_BAUD_HI, 8'h5a);
    rd(`UIF_ADDR_BAUD_HI, 8'h5a);
    chk(baud_divisor, 16'h5a02);
    $display("test fifo reset and divisor done");
    // Reset again in mid-run; divisor and request must return to idle
    @(posedge clk_sys) rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`UIF_ADDR_BAUD_HI, 8'h00);
    chk(irq, 1'b0);
    chk(fifo_reset, 1'b1);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : tb_uif_top
